/* File: rtl/spl_pkg.sv */
// Constants, register layout and carrier types for the system loop divider and lock control.
// Assumes a 32-bit APB master on the system clock and a reference clock sampled as a plain input.
package spl_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Bus and register map
	localparam int ADDR_W = 12;
	localparam logic [ADDR_W-1:0] LOOP_CTRL_OFS = 12'h000;
	localparam logic [ADDR_W-1:0] LOOP_STAT_OFS = 12'h004;

	// Control register fields
	localparam int FB_SEL_LSB = 0;
	localparam int FB_SEL_W = 5;
	localparam int POST_SEL_LSB = 5;
	localparam int POST_SEL_W = 2;
	localparam int BYPASS_BIT = 7;
	localparam int PD_BIT = 8;

	// Status register fields
	localparam int LOCK_BIT = 0;
	localparam int GOOD_LSB = 1;
	localparam int GOOD_W = 4;

	// Reset values: the loop starts powered down
	localparam logic [FB_SEL_W-1:0] FB_SEL_RST = 5'h00;
	localparam logic [POST_SEL_W-1:0] POST_SEL_RST = 2'h0;
	localparam logic BYPASS_RST = 1'b0;
	localparam logic PD_RST = 1'b1;

	////////////////////////////////////////////////////////////////////////////////
	// Lock detector timing
	localparam logic [GOOD_W-1:0] LOCK_RUN = 4'h8;
	localparam int PHASE_W = 8;
	localparam logic [PHASE_W-1:0] LOCK_WINDOW_DEF = 8'h02;

	////////////////////////////////////////////////////////////////////////////////
	// Carriers
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0] pwdata;
	} spl_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} spl_apb_rsp_t;

	typedef enum logic [1:0] {
		POST_DIV1 = 2'b00,
		POST_DIV2 = 2'b01,
		POST_DIV4 = 2'b10,
		POST_DIV8 = 2'b11
	} spl_post_sel_t;

endpackage : spl_pkg

/* File: rtl/spl_loop_ctrl.sv */
// Digital control of the system clock loop: post divider, feedback divider, lock detector,
// power-down handling and an APB register slave.
// Assumes ref_clk_in is synchronous to clk_sys and that the oscillator is modelled as a
// toggling flop advanced once per enabled system clock.
//
// Behaviour
// - Compare reference and feedback edges each reference period
// - Lock rises after more than eight good comparisons
// - One bad comparison clears counter and lock
// - Power-down stops oscillator, detector, resets dividers
// - Lock held low throughout power-down
// - After power-down, lock only once regained
// - Post divider divides by two times P
// - Feedback ratio M equals select plus one
// - Feedback clock is output divided by M
// - Bypass routes oscillator straight to output
// - Output equals M times reference, oscillator over 2P
`timescale 1ns/1ps

module spl_loop_ctrl #(
	parameter logic [spl_pkg::PHASE_W-1:0] LOCK_WINDOW = spl_pkg::LOCK_WINDOW_DEF
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	input wire spl_pkg::spl_apb_req_t apb_req,
	output spl_pkg::spl_apb_rsp_t apb_rsp,
	input wire logic ref_clk_in,
	output logic loop_clk_out,
	output logic fb_clk_out,
	output logic lock_out
);

	////////////////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		logic [spl_pkg::FB_SEL_W-1:0] fb_sel;
		logic [spl_pkg::POST_SEL_W-1:0] post_sel;
		logic bypass;
		logic pd;
		logic osc;
		logic [3:0] post_cnt;
		logic [spl_pkg::FB_SEL_W-1:0] fb_cnt;
		logic clk_out;
		logic fb_pulse;
		logic ref_prev;
		logic [spl_pkg::PHASE_W-1:0] since_fb;
		logic [spl_pkg::GOOD_W-1:0] good_cnt;
		logic lock;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} spl_state_t;

	spl_state_t st_reg;
	spl_state_t st_next;

	// P value for a post select code
	function automatic logic [3:0] spl_post_p(input logic [spl_pkg::POST_SEL_W-1:0] sel);
		case (spl_pkg::spl_post_sel_t'(sel))
			spl_pkg::POST_DIV1: spl_post_p = 4'h1;
			spl_pkg::POST_DIV2: spl_post_p = 4'h2;
			spl_pkg::POST_DIV4: spl_post_p = 4'h4;
			spl_pkg::POST_DIV8: spl_post_p = 4'h8;
			default: spl_post_p = 4'h1;
		endcase
	endfunction : spl_post_p

	logic ref_edge;
	logic phase_good;
	logic osc_rise;
	logic access_start;
	logic access_done;
	logic word_ctrl;
	logic word_stat;

	assign ref_edge = ref_clk_in & ~st_reg.ref_prev;
	assign phase_good = st_reg.since_fb <= LOCK_WINDOW;
	assign osc_rise = ~st_reg.osc;
	assign access_start = apb_req.psel & apb_req.penable & ~st_reg.pready;
	assign access_done = apb_req.psel & apb_req.penable & st_reg.pready;
	assign word_ctrl = apb_req.paddr[spl_pkg::ADDR_W-1:2] == spl_pkg::LOOP_CTRL_OFS[spl_pkg::ADDR_W-1:2];
	assign word_stat = apb_req.paddr[spl_pkg::ADDR_W-1:2] == spl_pkg::LOOP_STAT_OFS[spl_pkg::ADDR_W-1:2];

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		st_next = st_reg;
		st_next.fb_pulse = 1'b0;
		st_next.ref_prev = ref_clk_in;

		if (st_reg.pd) begin
			// Oscillator stopped, dividers and detector held in reset
			st_next.osc = 1'b0;
			st_next.post_cnt = 4'h0;
			st_next.fb_cnt = '0;
			st_next.clk_out = 1'b0;
			st_next.since_fb = '1;
			st_next.good_cnt = '0;
			st_next.lock = 1'b0;
		end else begin
			st_next.osc = ~st_reg.osc;
			if (st_reg.bypass) begin
				st_next.clk_out = ~st_reg.osc;
				st_next.post_cnt = 4'h0;
			end else if (osc_rise) begin
				// Toggle every P oscillator periods: period 2P, even duty
				if (st_reg.post_cnt == spl_post_p(st_reg.post_sel) - 4'h1) begin
					st_next.post_cnt = 4'h0;
					st_next.clk_out = ~st_reg.clk_out;
				end else begin
					st_next.post_cnt = st_reg.post_cnt + 4'h1;
				end
			end
			// Feedback pulse every M rising output edges
			if (st_next.clk_out & ~st_reg.clk_out) begin
				if (st_reg.fb_cnt == st_reg.fb_sel) begin
					st_next.fb_cnt = '0;
					st_next.fb_pulse = 1'b1;
				end else begin
					st_next.fb_cnt = st_reg.fb_cnt + 5'h01;
				end
			end
			if (st_next.fb_pulse) begin
				st_next.since_fb = '0;
			end else if (st_reg.since_fb != '1) begin
				st_next.since_fb = st_reg.since_fb + 8'h01;
			end
			// One comparison per reference period
			if (ref_edge) begin
				if (phase_good) begin
					if (st_reg.good_cnt <= spl_pkg::LOCK_RUN) begin
						st_next.good_cnt = st_reg.good_cnt + 4'h1;
					end
					st_next.lock = st_reg.good_cnt >= spl_pkg::LOCK_RUN;
				end else begin
					st_next.good_cnt = '0;
					st_next.lock = 1'b0;
				end
			end
		end

		// APB: decide in first access cycle, commit when pready is seen high
		st_next.pready = 1'b0;
		if (access_start) begin
			st_next.pready = 1'b1;
			st_next.pslverr = ~(word_ctrl | word_stat);
			st_next.prdata = 32'h0;
			if (!apb_req.pwrite && word_ctrl) begin
				st_next.prdata[spl_pkg::FB_SEL_LSB +: spl_pkg::FB_SEL_W] = st_reg.fb_sel;
				st_next.prdata[spl_pkg::POST_SEL_LSB +: spl_pkg::POST_SEL_W] = st_reg.post_sel;
				st_next.prdata[spl_pkg::BYPASS_BIT] = st_reg.bypass;
				st_next.prdata[spl_pkg::PD_BIT] = st_reg.pd;
			end else if (!apb_req.pwrite && word_stat) begin
				st_next.prdata[spl_pkg::LOCK_BIT] = st_reg.lock;
				st_next.prdata[spl_pkg::GOOD_LSB +: spl_pkg::GOOD_W] = st_reg.good_cnt;
			end
		end
		// Divider fields take effect at once; software should change them only in power-down
		if (access_done && apb_req.pwrite && word_ctrl) begin
			st_next.fb_sel = apb_req.pwdata[spl_pkg::FB_SEL_LSB +: spl_pkg::FB_SEL_W];
			st_next.post_sel = apb_req.pwdata[spl_pkg::POST_SEL_LSB +: spl_pkg::POST_SEL_W];
			st_next.bypass = apb_req.pwdata[spl_pkg::BYPASS_BIT];
			st_next.pd = apb_req.pwdata[spl_pkg::PD_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			st_reg <= '0;
			st_reg.fb_sel <= spl_pkg::FB_SEL_RST;
			st_reg.post_sel <= spl_pkg::POST_SEL_RST;
			st_reg.bypass <= spl_pkg::BYPASS_RST;
			st_reg.pd <= spl_pkg::PD_RST;
			st_reg.since_fb <= '1;
		end else if (ce) begin
			st_reg <= st_next;
		end
	end

	assign apb_rsp.prdata = st_reg.prdata;
	assign apb_rsp.pready = st_reg.pready;
	assign apb_rsp.pslverr = st_reg.pslverr;
	assign loop_clk_out = st_reg.clk_out;
	assign fb_clk_out = st_reg.fb_pulse;
	assign lock_out = st_reg.lock;

	////////////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking spl_cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	// Lock detector
	// Nine good edges are needed: the ninth is the one that sees a count of eight
	a_lock_after_run: assert property (
		$rose(lock_out)
		|-> $past(st_reg.good_cnt) >= spl_pkg::LOCK_RUN
		&& $past(ref_edge)
		&& $past(phase_good))
		else $error("Lock rose before nine good comparisons");

	a_lock_needs_run: assert property (
		lock_out
		|-> st_reg.good_cnt > spl_pkg::LOCK_RUN)
		else $error("Lock high without a full run of good comparisons");

	a_good_saturates: assert property (
		st_reg.good_cnt <= spl_pkg::LOCK_RUN + 4'h1)
		else $error("Good comparison count ran past its ceiling");

	a_bad_drops_lock: assert property (
		ce && !st_reg.pd && ref_edge && !phase_good
		|=> !lock_out
		&& st_reg.good_cnt == '0)
		else $error("Bad comparison did not clear lock detector");

	a_lock_drop_cause: assert property (
		$fell(lock_out)
		|-> $past(st_reg.pd)
		|| ($past(ref_edge) && !$past(phase_good)))
		else $error("Lock dropped without a bad comparison or power-down");

	a_count_on_ref: assert property (
		ce && !st_reg.pd && !ref_edge
		|=> st_reg.good_cnt == $past(st_reg.good_cnt))
		else $error("Good count moved without a reference edge");

	a_ref_sampled: assert property (
		ce
		|=> st_reg.ref_prev == $past(ref_clk_in))
		else $error("Reference sample not kept for edge detection");

	a_fb_restarts_gap: assert property (
		fb_clk_out
		|-> st_reg.since_fb == '0)
		else $error("Phase gap not restarted by feedback pulse");

	// Power-down and resume
	a_pd_resets_div: assert property (
		ce && st_reg.pd
		|=> st_reg.post_cnt == 4'h0
		&& st_reg.fb_cnt == '0
		&& !st_reg.osc
		&& !loop_clk_out
		&& !fb_clk_out)
		else $error("Dividers not held in reset during power-down");

	a_pd_gap_held: assert property (
		ce && st_reg.pd
		|=> st_reg.since_fb == '1)
		else $error("Phase detector not stopped in power-down");

	a_pd_lock_low: assert property (
		ce && st_reg.pd
		|=> !lock_out
		&& st_reg.good_cnt == '0)
		else $error("Lock not low during power-down");

	a_resume_no_lock: assert property (
		$fell(st_reg.pd)
		|-> !lock_out [*8])
		else $error("Lock rose too soon after power-down release");

	a_resume_count_zero: assert property (
		$fell(st_reg.pd)
		|-> st_reg.good_cnt == '0
		&& st_reg.since_fb == '1)
		else $error("Lock detector not restarted from zero");

	a_osc_runs: assert property (
		ce && !st_reg.pd
		|=> st_reg.osc != $past(st_reg.osc))
		else $error("Oscillator model stalled while running");

	// Dividers
	a_post_toggle: assert property (
		ce && !st_reg.pd && !st_reg.bypass && $changed(loop_clk_out)
		&& !$past(rst) && !$past(st_reg.pd) && !$past(st_reg.bypass)
		|-> $past(st_reg.post_cnt) == spl_post_p($past(st_reg.post_sel)) - 4'h1
		&& $past(osc_rise))
		else $error("Post divider toggled off its count");

	a_fb_ratio: assert property (
		$rose(fb_clk_out)
		|-> $past(st_reg.fb_cnt) == $past(st_reg.fb_sel)
		&& $rose(loop_clk_out))
		else $error("Feedback pulse not on every M-th output edge");

	a_fb_in_high: assert property (
		fb_clk_out
		|-> loop_clk_out)
		else $error("Feedback pulse outside a high output phase");

	a_fb_one_cycle: assert property (
		ce && fb_clk_out
		|=> !fb_clk_out)
		else $error("Feedback pulse longer than one cycle");

	a_bypass_route: assert property (
		ce && st_reg.bypass && !st_reg.pd
		&& $past(ce) && $past(st_reg.bypass) && !$past(st_reg.pd)
		|-> loop_clk_out == st_reg.osc)
		else $error("Bypass output does not follow oscillator");

	a_bypass_no_count: assert property (
		ce && st_reg.bypass && !st_reg.pd
		|=> st_reg.post_cnt == 4'h0)
		else $error("Post counter ran while bypassed");

	// Bus
	// pready falls on its own after one cycle; a master that keeps psel and penable high gets a new answer every second cycle
	a_apb_answer: assert property (
		ce && access_start
		|=> apb_rsp.pready ##1 !apb_rsp.pready || !ce)
		else $error("APB answer not a single cycle after access start");

	a_apb_no_stray: assert property (
		$past(ce) && !$past(access_start)
		|-> !apb_rsp.pready)
		else $error("APB ready without an access phase");

	a_apb_err_zero: assert property (
		apb_rsp.pready && apb_rsp.pslverr
		|-> apb_rsp.prdata == 32'h0)
		else $error("Refused access returned data");

	c_lock_rise: cover property ($rose(lock_out));
	c_pd_release: cover property ($fell(st_reg.pd));
	c_bad_compare: cover property (lock_out && ref_edge && !phase_good);
	c_bypass_run: cover property (st_reg.bypass && !st_reg.pd && $changed(loop_clk_out));
	c_apb_refused: cover property (apb_rsp.pready && apb_rsp.pslverr);

endmodule : spl_loop_ctrl

/* File: testbench/spl_ref_model.sv */
// Behavioural reference clock source standing in front of the loop.
// Assumes a feedback pulse on the system clock; the reference edge follows it dly plus one cycles after the pulse is sampled.
`timescale 1ns/1ps
module spl_ref_model (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic fb_clk_in,
	input wire logic [7:0] dly,
	output logic ref_clk_out
);
	logic [7:0] cnt_reg;
	logic run_reg;
	////////////////////////////////////////////////////////////////////////////////
	// Stands still until the first feedback pulse, so a powered-down loop sees no edges
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cnt_reg <= 8'h00;
			run_reg <= 1'b0;
			ref_clk_out <= 1'b0;
		end else begin
			if (fb_clk_in) begin
				cnt_reg <= 8'h00;
				run_reg <= 1'b1;
			end else if (cnt_reg != 8'hff) begin
				cnt_reg <= cnt_reg + 8'h01;
			end
			ref_clk_out <= run_reg && cnt_reg == dly && !fb_clk_in;
		end
	end
endmodule : spl_ref_model

/* File: testbench/system_pll_divider_lock_control_tb_top.sv */
// Self-checking bench for the loop control block: APB master, divider sweep and lock checks.
// Assumes the reference model tracks feedback pulses, so only its delay decides good or bad.
`timescale 1ns/1ps
module system_pll_divider_lock_control_tb_top;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	spl_pkg::spl_apb_req_t req = '0;
	spl_pkg::spl_apb_rsp_t rsp;
	logic ref_clk, loop_clk, fb_clk, lock;
	logic [7:0] dly = 8'h00;
	logic [31:0] rd;
	logic err;
	logic rp = 1'b0;
	logic ce = 1'b1;
	logic hold;
	int nref = 0;
	int n_mismatch = 0;
	int compares = 0;
	int seed = 32'h89279a99;
	int n, m, p, k, base;
	spl_loop_ctrl uut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .apb_req(req), .apb_rsp(rsp),
		.ref_clk_in(ref_clk), .loop_clk_out(loop_clk), .fb_clk_out(fb_clk), .lock_out(lock));
	spl_ref_model ref_src (.clk_sys(clk_sys), .rst(rst), .fb_clk_in(fb_clk), .dly(dly), .ref_clk_out(ref_clk));
	initial forever #5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		rp <= ref_clk;
		if (ref_clk && !rp) nref <= nref + 1;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic ok, input string msg);
		compares++;
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask : chk
	task automatic conclude();
		$display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : conclude
	task automatic apb(input logic wr, input logic [spl_pkg::ADDR_W-1:0] a, input logic [31:0] wd);
		int t;
		t = 0;
		@(posedge clk_sys);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
		@(posedge clk_sys);
		req.penable <= 1'b1;
		do begin
			@(posedge clk_sys);
			t++;
		end while (rsp.pready !== 1'b1 && t < 20);
		rd = rsp.prdata;
		err = rsp.pslverr;
		chk(t < 20, "no pready");
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask : apb
	function automatic logic [31:0] ctl(input logic pd, input logic byp, input logic [1:0] ps, input logic [4:0] fs);
		return (32'(pd) << spl_pkg::PD_BIT) | (32'(byp) << spl_pkg::BYPASS_BIT) | (32'(ps) << spl_pkg::POST_SEL_LSB) | 32'(fs);
	endfunction : ctl
	// Edges from here to the next sampled low-to-high step of the output clock
	task automatic rise(output int c);
		c = 0;
		do begin @(posedge clk_sys); c++; end while (loop_clk !== 1'b0 && c < 99);
		do begin @(posedge clk_sys); c++; end while (loop_clk !== 1'b1 && c < 99);
	endtask : rise
	task automatic quiet();
		repeat (2) @(posedge clk_sys);
		repeat (30) begin
			@(posedge clk_sys);
			chk(lock === 1'b0 && fb_clk === 1'b0 && loop_clk === 1'b0, "not quiet in power-down");
		end
	endtask : quiet
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(posedge clk_sys);
		rst <= 1'b0;
		apb(1'b0, spl_pkg::LOOP_CTRL_OFS, 32'h0);
		chk(rd === 32'h100 && err === 1'b0, "ctrl reset value");
		apb(1'b0, spl_pkg::LOOP_STAT_OFS, 32'h0);
		chk(rd === 32'h0, "status reset value");
		apb(1'b0, 12'h010, 32'h0);
		chk(err === 1'b1, "unmapped not refused");
		quiet();
		for (p = 0; p < 5; p++) begin
			m = $random(seed) & 3;
			apb(1'b1, spl_pkg::LOOP_CTRL_OFS, ctl(1'b1, p == 4, p[1:0], m[4:0]));
			apb(1'b1, spl_pkg::LOOP_CTRL_OFS, ctl(1'b0, p == 4, p[1:0], m[4:0]));
			rise(n);
			rise(n);
			chk(n === (p == 4 ? 2 : 4 << p), "output period");
			for (k = 0; k < 300 && fb_clk !== 1'b1; k++) @(posedge clk_sys);
			n = 0;
			do begin rise(k); n++; end while (fb_clk !== 1'b1 && n < 40);
			chk(n === m + 1, "feedback ratio");
			// Clock enable low for a random span must freeze the running loop
			k = ($random(seed) & 7) + 2;
			ce <= 1'b0;
			@(posedge clk_sys);
			hold = loop_clk;
			repeat (k) begin
				@(posedge clk_sys);
				chk(loop_clk === hold, "clock enable low did not freeze the loop");
			end
			ce <= 1'b1;
		end
		apb(1'b1, spl_pkg::LOOP_CTRL_OFS, ctl(1'b1, 1'b0, 2'h0, 5'h01));
		for (p = 0; p < 2; p++) begin
			apb(1'b1, spl_pkg::LOOP_CTRL_OFS, ctl(1'b0, 1'b0, 2'h0, 5'h01));
			base = nref;
			for (k = 0; k < 400 && lock !== 1'b1; k++) @(posedge clk_sys);
			chk(nref - base === 9, "lock after nine good edges");
			apb(1'b0, spl_pkg::LOOP_STAT_OFS, 32'h0);
			chk(rd[spl_pkg::LOCK_BIT] === 1'b1, "status lock");
			dly <= 8'h04;
			// Let an edge already launched with the old delay pass uncounted
			repeat (2) @(posedge clk_sys);
			base = nref;
			for (k = 0; k < 100 && nref == base; k++) @(posedge clk_sys);
			repeat (2) @(posedge clk_sys);
			chk(lock === 1'b0, "lock kept after bad edge");
			dly <= 8'h00;
			repeat (30) @(posedge clk_sys);
			apb(1'b1, spl_pkg::LOOP_CTRL_OFS, ctl(1'b1, 1'b0, 2'h0, 5'h01));
			quiet();
		end
		conclude();
	end
	initial begin
		#400000;
		chk(1'b0, "timeout");
		conclude();
	end
endmodule : system_pll_divider_lock_control_tb_top
